// file: rtl/prs_fault_timer.sv
// Qualification timer: flags a condition that persists for a set time
`timescale 1ns/10ps
module prs_fault_timer #(
  parameter int LIMIT = prs_pkg::RUN_FAULT_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Condition in, expiry flag out, held high while the condition lasts
  input  wire logic armed,
  input  wire logic cond,
  output logic      expired
);
  localparam int CW = $clog2(LIMIT + 1);
  initial begin
    if (LIMIT < 1) $error("LIMIT must be at least one");
  end

  logic [CW-1:0] cntReg;   // Cycles the condition has held
  logic [CW-1:0] cntNext;

  // Any break of the condition restarts the count
  always_comb begin
    cntNext = '0;
    if (armed && cond) begin
      cntNext = (cntReg == CW'(LIMIT)) ? cntReg : cntReg + CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cntReg <= '0;
    end else begin
      cntReg <= cntNext;
    end
  end

  // More than the limit, so fire one cycle past it
  assign expired = armed && cond && (cntReg == CW'(LIMIT));
endmodule // prs_fault_timer

// file: rtl/prs_pin_if.sv
// Interface carrying the filtered enable/programming pin events
`timescale 1ns/10ps
interface prs_pin_if;
  logic pinLevel;   // Filtered pin level
  logic pinRise;    // One-cycle pulse on a filtered rising edge
  logic pinOff;     // Level: pin low longer than the shutdown time
  modport src (output pinLevel, output pinRise, output pinOff);
  modport dst (input pinLevel, input pinRise, input pinOff);
endinterface // prs_pin_if

// file: rtl/prs_pin_sync.sv
// Synchroniser, edge detector and low-time detector for the control pin
`timescale 1ns/10ps
module prs_pin_sync #(
  parameter int OFF_CYC = prs_pkg::OFF_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Raw pin
  input  wire logic ctrlPin,
  // Events to the sequencer
  prs_pin_if.src    pin
);
  localparam int CW = $clog2(OFF_CYC + 1);
  initial begin
    if (OFF_CYC < 1) $error("OFF_CYC must be at least one");
  end

  logic [2:0]    syncReg;     // Three-stage synchroniser
  logic [2:0]    syncNext;
  logic          levelReg;    // Accepted level
  logic          levelNext;
  logic [CW-1:0] lowCntReg;   // Cycles spent low
  logic [CW-1:0] lowCntNext;

  // Level changes only when stages two and three agree
  always_comb begin
    syncNext   = {syncReg[1:0], ctrlPin};
    levelNext  = (syncReg[2] == syncReg[1]) ? syncReg[2] : levelReg;
    lowCntNext = lowCntReg;
    if (levelReg) begin
      lowCntNext = '0;
    end else if (lowCntReg != CW'(OFF_CYC)) begin
      lowCntNext = lowCntReg + CW'(1);
    end
  end

  // Registers only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      syncReg   <= 3'h0;
      levelReg  <= 1'b0;
      lowCntReg <= CW'(OFF_CYC);
    end else begin
      syncReg   <= syncNext;
      levelReg  <= levelNext;
      lowCntReg <= lowCntNext;
    end
  end

  assign pin.pinLevel = levelReg;
  assign pin.pinRise  = levelNext & ~levelReg;
  // Short low gaps stay programming gaps
  assign pin.pinOff   = (lowCntReg == CW'(OFF_CYC));
endmodule // prs_pin_sync

// file: rtl/prs_pkg.sv
// Package with timing constants, codes and states of the rail sequencer
package prs_pkg;
  // Time base
  localparam int CLK_MHZ            = 25;
  // Programming pulse window at the host pin, microseconds
  localparam int PULSE_MIN_US       = 2;
  localparam int PULSE_MAX_US       = 25;
  // Low time that means disable, microseconds (typ / max)
  localparam int OFF_TYP_US         = 30;
  localparam int OFF_MAX_US         = 80;
  localparam int OFF_CYC            = OFF_TYP_US * CLK_MHZ;
  // Sequencing and fault times, milliseconds
  localparam int NEG_DELAY_MS       = 10;
  localparam int START_CHK1_MS      = 10;
  localparam int START_CHK2_MS      = 20;
  localparam int RUN_FAULT_MS       = 3;
  localparam int NEG_DELAY_CYC      = NEG_DELAY_MS * 1000 * CLK_MHZ;
  localparam int START_CHK1_CYC     = START_CHK1_MS * 1000 * CLK_MHZ;
  localparam int START_CHK2_CYC     = START_CHK2_MS * 1000 * CLK_MHZ;
  localparam int RUN_FAULT_CYC      = RUN_FAULT_MS * 1000 * CLK_MHZ;
  // Setting code width and limits
  localparam int CODE_W             = 5;
  localparam logic [4:0] CODE_DEFAULT = 5'h00;
  localparam logic [4:0] CODE_MAX     = 5'h1F;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_SOFT  = 3'b001,
    ST_BOTH  = 3'b010,
    ST_RUN   = 3'b011,
    ST_LATCH = 3'b100
  } prs_state_t;
endpackage : prs_pkg

// file: rtl/prs_rail_sequencer.sv
// Top of the dual-rail supply sequencer with pulse-count programming
// What this block does
// - Negative rail starts at minus four volts
// - Rising edges select setting, zero keeps default
// - High pin starts boost with soft current limit
// - Negative converter starts 10 ms after enable
// - Pin low keeps everything shut down
// - Start needs pin high and supply good
// - Supply lockout disables all operation
// - Running rail faults qualified for 3 ms
// - Rail fault latches both converters off
// - Pin toggle or power cycle clears latch
// - Start-up checks at 10 and 20 ms
// - Over-temperature stops every function
// - Discharge both outputs while shut down
// - Long low means disable, short low gap
`timescale 1ns/10ps
module prs_rail_sequencer #(
  parameter int NEG_DELAY_CYC  = prs_pkg::NEG_DELAY_CYC,
  parameter int START_CHK1_CYC = prs_pkg::START_CHK1_CYC,
  parameter int START_CHK2_CYC = prs_pkg::START_CHK2_CYC,
  parameter int RUN_FAULT_CYC  = prs_pkg::RUN_FAULT_CYC,
  parameter int OFF_CYC        = prs_pkg::OFF_CYC
) (
  // Clock and reset (power-on)
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  // Host enable/programming pin
  input  wire logic                      ctrlPin,
  // Analog status, same clock domain
  input  wire logic                      supplyLowLockout,
  input  wire logic                      overTemp,
  input  wire logic                      posRegulated,
  input  wire logic                      posBelowShort,
  input  wire logic                      negRegulated,
  input  wire logic                      negAboveStartThr,
  input  wire logic                      negAboveRunThr,
  // Converter controls
  output logic                           posEnable,
  output logic                           posSoftLimit,
  output logic                           negEnable,
  output logic [prs_pkg::CODE_W-1:0]     negativeRailCode,
  output logic                           posDischarge,
  output logic                           negDischarge,
  // Status
  output logic                           faultLatched
);
  localparam int TW = $clog2(START_CHK2_CYC + 1);
  initial begin
    if (NEG_DELAY_CYC < 1 || START_CHK1_CYC < NEG_DELAY_CYC ||
        START_CHK2_CYC <= START_CHK1_CYC) begin
      $error("Start-up timing parameters out of order");
    end
  end

  prs_pin_if pin ();

  // Pin conditioning
  prs_pin_sync #(.OFF_CYC(OFF_CYC)) uSync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .ctrlPin (ctrlPin),
    .pin     (pin)
  );

  prs_pkg::prs_state_t stateReg;   // Sequencer state
  prs_pkg::prs_state_t stateNext;
  logic [TW-1:0]       timeReg;    // Cycles since enable
  logic [TW-1:0]       timeNext;
  logic [4:0]          codeReg;    // Rising-edge count
  logic [4:0]          codeNext;
  logic                latchReg;   // Sticky fault or thermal shutdown
  logic                latchNext;
  logic                runPosFlt;  // Qualified running faults
  logic                runNegFlt;
  logic                halt;       // Lockout or thermal stop
  logic                startFlt;   // Start-up check failed
  logic                running;

  assign halt    = supplyLowLockout | overTemp;
  assign running = (stateReg == prs_pkg::ST_RUN);

  // Running short detection, qualified for the set time
  prs_fault_timer #(.LIMIT(RUN_FAULT_CYC)) uPosTmr (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .armed   (running),
    .cond    (posBelowShort),
    .expired (runPosFlt)
  );
  prs_fault_timer #(.LIMIT(RUN_FAULT_CYC)) uNegTmr (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .armed   (running),
    .cond    (negAboveRunThr),
    .expired (runNegFlt)
  );

  // Start-up checks at fixed times after enable
  always_comb begin
    startFlt = 1'b0;
    if (stateReg == prs_pkg::ST_BOTH) begin
      if (timeReg == TW'(START_CHK1_CYC) && (!posRegulated || negAboveStartThr)) begin
        startFlt = 1'b1;
      end
      if (timeReg == TW'(START_CHK2_CYC) && !negRegulated) begin
        startFlt = 1'b1;
      end
    end
  end

  // Next state, timer, edge count and latch
  always_comb begin
    stateNext = stateReg;
    timeNext  = timeReg;
    codeNext  = codeReg;
    latchNext = latchReg;
    if (halt) begin
      // Lockout or thermal stop wins over everything
      stateNext = prs_pkg::ST_OFF;
      codeNext  = prs_pkg::CODE_DEFAULT;
      timeNext  = '0;
      if (overTemp) begin
        latchNext = 1'b1;
      end
      if (supplyLowLockout) begin
        latchNext = 1'b0;  // Power cycle clears the latch
      end
    end else if (pin.pinOff) begin
      // Long low: shut down, clear count and latch
      stateNext = prs_pkg::ST_OFF;
      codeNext  = prs_pkg::CODE_DEFAULT;
      timeNext  = '0;
      latchNext = 1'b0;
    end else begin
      if (pin.pinRise && stateReg != prs_pkg::ST_OFF && codeReg != prs_pkg::CODE_MAX) begin
        codeNext = codeReg + 5'h01;
      end
      if (timeReg != TW'(START_CHK2_CYC)) begin
        timeNext = timeReg + TW'(1);
      end
      case (stateReg)
        prs_pkg::ST_OFF: begin
          timeNext = '0;
          // A set latch keeps the block off even with the pin high
          if (pin.pinLevel && !latchReg) begin
            stateNext = prs_pkg::ST_SOFT;
          end
        end
        prs_pkg::ST_SOFT: begin
          // Boost alone with its soft limit until the delay runs out
          if (timeReg == TW'(NEG_DELAY_CYC - 1)) begin
            stateNext = prs_pkg::ST_BOTH;
          end
        end
        prs_pkg::ST_BOTH: begin
          if (startFlt) begin
            stateNext = prs_pkg::ST_LATCH;
            latchNext = 1'b1;
          end else if (timeReg == TW'(START_CHK2_CYC)) begin
            stateNext = prs_pkg::ST_RUN;
          end
        end
        prs_pkg::ST_RUN: begin
          if (runPosFlt || runNegFlt) begin
            stateNext = prs_pkg::ST_LATCH;
            latchNext = 1'b1;
          end
        end
        prs_pkg::ST_LATCH: begin
          stateNext = prs_pkg::ST_LATCH;  // Wait for toggle or power cycle
        end
        default: begin
          stateNext = prs_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Registers only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stateReg <= prs_pkg::ST_OFF;
      timeReg  <= '0;
      codeReg  <= prs_pkg::CODE_DEFAULT;
      latchReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      timeReg  <= timeNext;
      codeReg  <= codeNext;
      latchReg <= latchNext;
    end
  end

  // Outputs decoded from registered state only
  always_comb begin
    posEnable    = (stateReg == prs_pkg::ST_SOFT) || (stateReg == prs_pkg::ST_BOTH) ||
                   running;
    posSoftLimit = (stateReg == prs_pkg::ST_SOFT);
    negEnable    = (stateReg == prs_pkg::ST_BOTH) || running;
    posDischarge = !posEnable;
    negDischarge = !negEnable;
  end
  // Code zero means the default minus four volts
  assign negativeRailCode = codeReg;
  assign faultLatched     = latchReg;

  // Checks
  // They watch outputs, internal state and the status inputs
  // Long waits are measured by counters, never by long repetitions
  chk_neg_delay: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(posEnable) |-> !negEnable [*8]);

  // Shutdown paths: long low, lockout and over-temperature
  chk_pin_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    pin.pinOff |=> !posEnable && !negEnable);
  chk_halt_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    halt |=> !posEnable && !negEnable && posDischarge && negDischarge);

  // Programming count stays inside the table
  chk_code_sat: assert property (@(posedge ref_clk) disable iff (!resetn)
    codeReg == prs_pkg::CODE_MAX |=> codeReg == prs_pkg::CODE_MAX || $fell(posEnable)
    || codeReg == prs_pkg::CODE_DEFAULT);

  // Fault latch set and hold
  chk_run_fault: assert property (@(posedge ref_clk) disable iff (!resetn)
    running && (runPosFlt || runNegFlt) && !halt && !pin.pinOff |=> faultLatched && !posEnable);
  chk_latch_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    faultLatched && !pin.pinOff && !supplyLowLockout |=> faultLatched);

  // Start conditions and the first phase
  chk_start_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(posEnable) |-> $past(pin.pinLevel) && !$past(supplyLowLockout));
  chk_code_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    pin.pinOff |=> negativeRailCode == prs_pkg::CODE_DEFAULT);
  chk_soft_first: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(posEnable) |-> posSoftLimit && negativeRailCode == prs_pkg::CODE_DEFAULT);

  // Observation counter for the delay check: cycles the boost has run alone.
  // Kept apart from timeReg so that the check does not lean on the logic it guards.
  logic [TW-1:0] soloCntReg;   // Cycles with boost on and negative converter off
  logic [TW-1:0] soloCntNext;

  // Counts while the boost runs alone, holds while both run, clears when off
  always_comb begin
    soloCntNext = '0;
    if (posEnable && !negEnable) begin
      soloCntNext = (soloCntReg == TW'(START_CHK2_CYC)) ? soloCntReg : soloCntReg + TW'(1);
    end else if (posEnable) begin
      soloCntNext = soloCntReg;  // Final count kept for the check
    end
  end

  // Registers only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      soloCntReg <= '0;
    end else begin
      soloCntReg <= soloCntNext;
    end
  end

  // Steps of the delayed start: negative converter on, boost out of soft start
  sequence seqNegStart;
    $rose(negEnable);
  endsequence
  sequence seqBoostFull;
    posEnable && !posSoftLimit;
  endsequence

  // The negative converter waits the full delay after the boost starts
  chk_neg_timing: assert property (@(posedge ref_clk) disable iff (!resetn)
    seqNegStart |-> seqBoostFull ##0 (soloCntReg == TW'(NEG_DELAY_CYC)));

  // An unregulated positive rail at the first check or negative rail at the second latches the shutdown
  chk_start_early: assert property (@(posedge ref_clk) disable iff (!resetn)
    stateReg == prs_pkg::ST_BOTH && timeReg == TW'(START_CHK1_CYC) && !posRegulated &&
    !halt && !pin.pinOff |=> faultLatched && !negEnable);
  chk_start_late: assert property (@(posedge ref_clk) disable iff (!resetn)
    stateReg == prs_pkg::ST_BOTH && timeReg == TW'(START_CHK2_CYC) && !negRegulated &&
    !halt && !pin.pinOff |=> faultLatched && !negEnable);

  // Each programming edge accepted while running adds exactly one below the top code
  chk_edge_count: assert property (@(posedge ref_clk) disable iff (!resetn)
    pin.pinRise && running && !halt && !pin.pinOff && codeReg != prs_pkg::CODE_MAX |=>
    codeReg == $past(codeReg) + 5'h01);

  // A rail that stays in range never latches the running converters off
  chk_run_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    running && !halt && !pin.pinOff && !posBelowShort && !negAboveRunThr |=>
    !faultLatched && posEnable);

  // Over-temperature latches everything off unless the supply is already gone
  chk_hot_latch: assert property (@(posedge ref_clk) disable iff (!resetn)
    overTemp && !supplyLowLockout |=> faultLatched && !posEnable && !negEnable);

  // Supply lockout acts as the power cycle that frees the latch
  chk_power_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    supplyLowLockout |=> !faultLatched);

  // Both outputs are pulled down whenever both converters are off
  chk_discharge_on: assert property (@(posedge ref_clk) disable iff (!resetn)
    !posEnable && !negEnable |-> posDischarge && negDischarge);
endmodule // prs_rail_sequencer

// file: tb/prs_host_model.sv
// Host controller model driving the enable/programming pin
`timescale 1ns/10ps
module prs_host_model (
  // Clock the host steps on
  ref_clk,
  // Pin with pull-down, low at power-up
  ctrlPin
);
  input  wire logic ref_clk;
  output logic      ctrlPin;

  // Pull-down keeps the pin low until the host drives it
  initial ctrlPin = 1'b0;

  // Hold a level for a count of cycles, changed only at the falling edge
  task automatic drive(input logic lvl, input int cyc);
    @(negedge ref_clk);
    ctrlPin = lvl;
    repeat (cyc) @(negedge ref_clk);
  endtask

  // Programming pulses; random widths model a slow and a prompt host
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      drive(1'b0, 50 + $urandom_range(70));
      drive(1'b1, 50 + $urandom_range(70));
    end
  endtask
endmodule // prs_host_model

// file: tb/prs_rail_sequencer_tb.sv
// Self-checking bench for the rail sequencer
`timescale 1ns/10ps
module prs_rail_sequencer_tb;
  // Shortened sequencing counts, NEG <= CK1 < CK2
  localparam int NEG = 200;
  localparam int CK1 = 300;
  localparam int CK2 = 500;
  localparam int RUF = 100;
  localparam int OFF = prs_pkg::OFF_CYC;
  // Clock, reset and analog status
  logic                       ref_clk = 1'b0;
  logic                       resetn  = 1'b0;
  logic                       ctrlPin;
  logic                       supplyLowLockout = 1'b0;
  logic                       overTemp = 1'b0;
  logic [4:0]                 rail;
  // Outputs
  logic                       posEnable;
  logic                       posSoftLimit;
  logic                       negEnable;
  logic [prs_pkg::CODE_W-1:0] negativeRailCode;
  logic                       posDischarge;
  logic                       negDischarge;
  logic                       faultLatched;
  // Scoreboard
  int                         err_total = 0;
  int                         checks = 0;
  int                         t;
  int                         n;

  // Free-running 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  prs_host_model host (.ref_clk(ref_clk), .ctrlPin(ctrlPin));

  prs_rail_sequencer #(.NEG_DELAY_CYC(NEG), .START_CHK1_CYC(CK1), .START_CHK2_CYC(CK2),
    .RUN_FAULT_CYC(RUF), .OFF_CYC(OFF)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .ctrlPin(ctrlPin),
    .supplyLowLockout(supplyLowLockout), .overTemp(overTemp),
    .posRegulated(rail[4]), .posBelowShort(rail[3]), .negRegulated(rail[2]),
    .negAboveStartThr(rail[1]), .negAboveRunThr(rail[0]),
    .posEnable(posEnable), .posSoftLimit(posSoftLimit), .negEnable(negEnable),
    .negativeRailCode(negativeRailCode), .posDischarge(posDischarge),
    .negDischarge(negDischarge), .faultLatched(faultLatched));

  // Compare one value, count it, report a mismatch at once
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s (got %0h, want %0h)", $time, msg, seen, exp);
    end
  endtask

  // Final counts and verdict, the only place the run ends
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Output picked by index, so one bounded wait serves posEnable, negEnable and faultLatched
  function automatic logic pick(input int k);
    return (k == 0) ? posEnable : (k == 1) ? negEnable : faultLatched;
  endfunction

  // Bounded wait for a flag; running out counts as a mismatch
  task automatic waitHi(input int k, input int lim, output int cnt);
    cnt = 0;
    while (pick(k) !== 1'b1 && cnt < lim) begin
      @(negedge ref_clk);
      cnt++;
    end
    if (pick(k) !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: wait %0d timed out", $time, k);
      summarize();
    end
  endtask

  // Fault time is allowed a small pipeline slack around the nominal count
  function automatic logic inWin(input int tm, input int c);
    return (tm >= c - 1) && (tm <= c + 3);
  endfunction

  // Everything off with discharge on, plus expected latch state
  task automatic offChk(input logic lat);
    chk({posEnable, posSoftLimit, negEnable}, 16'h0, "converter left on");
    chk({posDischarge, negDischarge}, 16'h3, "discharge not active");
    chk(faultLatched, lat, "fault latch state");
  endtask

  // Disable long enough, then raise the pin and wait for the boost start
  task automatic enable(input logic toRun);
    host.drive(1'b0, OFF + 20);
    host.drive(1'b1, 0);
    waitHi(0, 10, t);
    if (toRun) repeat (CK2 + 10) @(negedge ref_clk);
  endtask

  initial begin
    void'($urandom(32'hAC49));
    rail = 5'b10100;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    offChk(1'b0);
    chk(negativeRailCode, 16'h0, "reset code");

    // Lockout holds the block off even with the pin high
    supplyLowLockout = 1'b1;
    host.drive(1'b1, 40);
    offChk(1'b0);
    supplyLowLockout = 1'b0;
    $display("test lockout done");

    // Soft start, then the negative converter after its delay
    enable(1'b0);
    chk({posSoftLimit, negEnable, negDischarge}, 16'h5, "soft start phase");
    chk(negativeRailCode, 16'h0, "default code");
    waitHi(1, NEG + 10, t);
    chk(t[15:0], 16'(NEG), "negative start delay");
    chk(posSoftLimit, 1'b0, "soft limit kept");
    $display("test start done");

    // Random programming count, then saturation at the top code
    repeat (CK2) @(negedge ref_clk);
    n = 1 + $urandom_range(29);
    host.pulses(n);
    repeat (8) @(negedge ref_clk);
    chk(negativeRailCode, n[15:0], "edge count");
    chk(posEnable, 1'b1, "short gap disabled");
    host.pulses(32 - n);
    repeat (8) @(negedge ref_clk);
    chk(negativeRailCode, 16'h1F, "count saturation");
    host.drive(1'b0, OFF + 20);
    offChk(1'b0);
    chk(negativeRailCode, 16'h0, "code cleared");
    $display("test program done");

    // Running faults: a short blip is ignored, a long one latches
    for (int k = 0; k < 2; k++) begin
      enable(1'b1);
      rail[3 - 3 * k] = ~rail[3 - 3 * k];
      repeat (RUF / 2) @(negedge ref_clk);
      rail = 5'b10100;
      repeat (4) @(negedge ref_clk);
      chk(faultLatched, 1'b0, "blip latched");
      rail[3 - 3 * k] = 1'b1;
      waitHi(2, RUF + 10, t);
      chk(inWin(t, RUF + 1), 1'b1, "run fault time");
      repeat (2) @(negedge ref_clk);
      offChk(1'b1);
      rail = 5'b10100;
      enable(1'b1);
      chk({faultLatched, negEnable}, 16'h1, "no restart after toggle");
    end
    $display("test run fault done");

    // Start-up checks at the first and second check times
    for (int k = 0; k < 3; k++) begin
      host.drive(1'b0, OFF + 20);
      rail = (k == 0) ? 5'b00100 : (k == 1) ? 5'b10110 : 5'b10000;
      enable(1'b0);
      waitHi(2, CK2 + 10, t);
      chk(inWin(t, (k == 2) ? CK2 : CK1), 1'b1, "start fault time");
      repeat (2) @(negedge ref_clk);
      offChk(1'b1);
      rail = 5'b10100;
    end
    $display("test start fault done");

    // Over-temperature stops everything; a power cycle clears the latch
    enable(1'b1);
    overTemp = 1'b1;
    repeat (6) @(negedge ref_clk);
    overTemp = 1'b0;
    offChk(1'b1);
    supplyLowLockout = 1'b1;
    repeat (3) @(negedge ref_clk);
    offChk(1'b0);
    supplyLowLockout = 1'b0;
    // Supply back with the pin still high: the sequence starts again
    waitHi(0, 10, t);
    chk(posEnable, 1'b1, "no restart after power cycle");
    $display("test thermal done");
    summarize();
  end
endmodule // prs_rail_sequencer_tb
